// ---- hdl/conv3x3_pkg.sv ----
// Shared constants, types and carriers of the 3x3 image filter
package conv3x3_pkg;

    // ************************************************
    // Image and datapath geometry
    // ************************************************
    localparam int IMG_W       = 8;                 // Pixels per row
    localparam int IMG_H       = 8;                 // Rows per frame
    localparam int PIX_W       = 8;                 // Unsigned grey level
    localparam int COEF_W      = 9;                 // Signed weight width
    localparam int TAPS        = 9;                 // Kernel positions
    localparam int LINES       = 3;                 // Rotating line memories
    localparam int ACC_W       = 21;                // Worst-case sum fits
    localparam int FIFO_DEPTH  = 32;                // Input buffer words

    // ************************************************
    // Counts and reset values
    // ************************************************
    localparam logic [5:0] CNT_RST     = 6'h00;     // Pixel counters
    localparam logic [5:0] LAST_PIX    = 6'h3F;     // Index of bottom-right
    localparam logic [5:0] FIRST_OUT   = 6'h09;     // Index of the input that enables 1st output
    localparam logic [2:0] LAST_COL    = 3'h7;      // Rightmost column
    localparam logic [2:0] LAST_ROW    = 3'h7;      // Bottom row
    localparam logic [3:0] FLUSH_LAST  = 4'h8;      // Nine flush steps, 0..8
    localparam logic [3:0] FLUSH_RST   = 4'h0;
    localparam logic [1:0] LINE_RST    = 2'h0;      // Row 0 lands in line 0

    // ************************************************
    // Types
    // ************************************************
    typedef logic [PIX_W-1:0]         pix_t;
    typedef logic signed [COEF_W-1:0] coef_t;
    typedef coef_t [TAPS-1:0]         kernel_t;     // [0]=top-left, [8]=bottom-right

    typedef struct packed {
        logic                    frame_end;         // Last pixel of the image
        logic signed [ACC_W-1:0] value;             // Filtered pixel
    } out_pix_t;

    typedef enum logic {
        ST_FILL  = 1'b0,                            // Taking input pixels
        ST_FLUSH = 1'b1                             // Emitting the last nine outputs
    } eng_state_t;

endpackage

// ---- hdl/conv3x3_fifo.sv ----
// Parameterised valid/ready FIFO in front of the filter engine
`timescale 1ns/100ps
module conv3x3_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_clr,       // Synchronous flush
    input  wire logic         i_in_valid,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_in_ready,
    output logic              o_out_valid,
    output logic [W-1:0]      o_out_data,
    input  wire logic         i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];            // Storage words
    logic [AW-1:0] wr_r, wr_nxt;           // Write pointer
    logic [AW-1:0] rd_r, rd_nxt;           // Read pointer
    logic [AW:0]   cnt_r, cnt_nxt;         // Fill level
    logic          rdy_r, rdy_nxt;         // Registered not-full
    logic          vld_r, vld_nxt;         // Registered not-empty
    logic          push, pop;

    assign push        = i_in_valid & rdy_r;
    assign pop         = vld_r & i_out_ready;
    assign o_in_ready  = rdy_r;
    assign o_out_valid = vld_r;
    assign o_out_data  = mem[rd_r];

    // Pointer and level update; flags derived from the next level
    always_comb begin
        wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = (AW+1)'(cnt_r + {AW'(0), push} - {AW'(0), pop});
        if (i_clr) begin
            wr_nxt  = '0;
            rd_nxt  = '0;
            cnt_nxt = '0;
        end
        rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
        vld_nxt = cnt_nxt != '0;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
            vld_r <= 1'b0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            vld_r <= vld_nxt;
        end
    end

    // Storage holds no control state, so it needs no reset
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_r] <= i_in_data;
        end
    end
endmodule

// ---- hdl/conv3x3_filter.sv ----
// 3x3 convolution engine: line memories, zero padding, nine multipliers
`timescale 1ns/100ps
// Overview of operation
// - Output is nine weight-times-neighbour products summed
// - Rows rotate through three line memories
// - Nine 9-bit signed weights feed multipliers directly
// - Neighbours outside the image count as zero
// - All nine products formed at once, then added
// - One output pixel per input pixel
// - Symmetric kernels may pre-add pixels, then multiply
module conv3x3_filter (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_frame_clr,
    input  wire logic                 i_pix_valid,
    input  wire conv3x3_pkg::pix_t    i_pix,
    output logic                      o_pix_ready,
    input  wire conv3x3_pkg::kernel_t i_kernel,
    input  wire logic                 i_sym_mode,
    output logic                      o_out_valid,
    output conv3x3_pkg::out_pix_t     o_out_pix,
    input  wire logic                 i_out_ready
);

    // ************************************************
    // Declarations
    // ************************************************
    conv3x3_pkg::pix_t       f_pix;                 // Head of the FIFO
    logic                    f_vld;                 // FIFO not empty
    logic                    stall;                 // Consumer holds output
    logic                    take;                  // Pixel consumed this cycle
    logic                    flush_step;            // Trailing output step
    logic                    calc_fire;             // Window turns into output
    conv3x3_pkg::eng_state_t state_r, state_nxt;
    logic [5:0]              in_cnt_r, in_cnt_nxt;  // {row, col} of next input
    logic [1:0]              wr_line_r, wr_line_nxt;
    logic [3:0]              flush_r, flush_nxt;
    logic                    calc_r, calc_nxt;      // Window ready to compute
    logic [5:0]              out_r, out_nxt;        // {row, col} of next output
    logic                    ovld_r, ovld_nxt;
    conv3x3_pkg::out_pix_t   opix_r, opix_nxt;
    conv3x3_pkg::pix_t       line_mem [conv3x3_pkg::LINES][conv3x3_pkg::IMG_W];
    conv3x3_pkg::pix_t       tap_pix [conv3x3_pkg::TAPS];   // Padded window
    logic signed [17:0]      prod [conv3x3_pkg::TAPS];      // Direct products
    logic [conv3x3_pkg::TAPS-1:0]          tap_ok;          // Inside image
    logic signed [conv3x3_pkg::ACC_W-1:0]  full_sum;
    logic signed [conv3x3_pkg::ACC_W-1:0]  sym_sum;
    logic [9:0]              edge_sum;              // Four edge neighbours
    logic [9:0]              corner_sum;            // Four corner neighbours
    logic signed [19:0]      edge_prod, corner_prod;
    logic signed [17:0]      centre_prod;
    logic                    sym_kernel;            // Kernel has three weights

    // Row number to line memory, row mod 3
    function automatic logic [1:0] line_of(input logic [2:0] row);
        unique case (row)
            3'h0, 3'h3, 3'h6: line_of = 2'h0;
            3'h1, 3'h4, 3'h7: line_of = 2'h1;
            default:          line_of = 2'h2;
        endcase
    endfunction

    // ************************************************
    // Input buffering
    // ************************************************
    conv3x3_fifo #(
        .W     (conv3x3_pkg::PIX_W),
        .DEPTH (conv3x3_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rstn      (i_rstn),
        .i_clr       (i_frame_clr),
        .i_in_valid  (i_pix_valid),
        .i_in_data   (i_pix),
        .o_in_ready  (o_pix_ready),
        .o_out_valid (f_vld),
        .o_out_data  (f_pix),
        .i_out_ready (take)
    );

    // ************************************************
    // Sequencing
    // ************************************************
    // A stalled output freezes the whole engine, so back-pressure
    // reaches the FIFO and then the source
    assign stall      = ovld_r & ~i_out_ready;
    assign take       = (state_r == conv3x3_pkg::ST_FILL) & f_vld & ~stall & ~i_frame_clr;
    assign flush_step = (state_r == conv3x3_pkg::ST_FLUSH) & ~stall;
    assign calc_fire  = calc_r & ~stall;

    // Next state of counters, engine state and output register
    always_comb begin
        state_nxt   = state_r;
        in_cnt_nxt  = in_cnt_r;
        wr_line_nxt = wr_line_r;
        flush_nxt   = flush_r;
        calc_nxt    = stall ? calc_r : 1'b0;
        out_nxt     = out_r;
        ovld_nxt    = stall ? ovld_r : 1'b0;
        opix_nxt    = opix_r;
        if (take) begin
            in_cnt_nxt = 6'(in_cnt_r + 1'b1);
            // Output k-9 becomes computable once pixel k is stored
            calc_nxt   = in_cnt_r >= conv3x3_pkg::FIRST_OUT;
            // Move to the next line memory at each row end
            if (in_cnt_r[2:0] == conv3x3_pkg::LAST_COL) begin
                wr_line_nxt = line_of(3'(in_cnt_r[5:3] + 1'b1));
            end
            if (in_cnt_r == conv3x3_pkg::LAST_PIX) begin
                state_nxt   = conv3x3_pkg::ST_FLUSH;
                in_cnt_nxt  = conv3x3_pkg::CNT_RST;
                wr_line_nxt = conv3x3_pkg::LINE_RST;
                flush_nxt   = conv3x3_pkg::FLUSH_RST;
            end
        end
        // Last nine outputs have no later input to trigger them
        if (flush_step) begin
            calc_nxt  = 1'b1;
            flush_nxt = 4'(flush_r + 1'b1);
            if (flush_r == conv3x3_pkg::FLUSH_LAST) begin
                state_nxt = conv3x3_pkg::ST_FILL;
            end
        end
        // Window result leaves with its strobe, in raster order
        if (calc_fire) begin
            out_nxt         = 6'(out_r + 1'b1);
            ovld_nxt        = 1'b1;
            opix_nxt.value  = i_sym_mode ? sym_sum : full_sum;
            opix_nxt.frame_end = out_r == conv3x3_pkg::LAST_PIX;
        end
        // Clear returns everything to the top-left of a new frame
        if (i_frame_clr) begin
            state_nxt   = conv3x3_pkg::ST_FILL;
            in_cnt_nxt  = conv3x3_pkg::CNT_RST;
            wr_line_nxt = conv3x3_pkg::LINE_RST;
            flush_nxt   = conv3x3_pkg::FLUSH_RST;
            calc_nxt    = 1'b0;
            out_nxt     = conv3x3_pkg::CNT_RST;
            ovld_nxt    = 1'b0;
        end
    end

    // Register the sequencing state; nothing but flops here
    // Reset parks the engine at the top-left of an empty frame
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r   <= conv3x3_pkg::ST_FILL;
            in_cnt_r  <= conv3x3_pkg::CNT_RST;
            wr_line_r <= conv3x3_pkg::LINE_RST;
            flush_r   <= conv3x3_pkg::FLUSH_RST;
            calc_r    <= 1'b0;
            out_r     <= conv3x3_pkg::CNT_RST;
            ovld_r    <= 1'b0;
            opix_r    <= '0;
        end else begin
            state_r   <= state_nxt;
            in_cnt_r  <= in_cnt_nxt;
            wr_line_r <= wr_line_nxt;
            flush_r   <= flush_nxt;
            calc_r    <= calc_nxt;
            out_r     <= out_nxt;
            ovld_r    <= ovld_nxt;
            opix_r    <= opix_nxt;
        end
    end

    // Both outputs leave straight from the registers above
    assign o_out_valid = ovld_r;
    assign o_out_pix   = opix_r;

    // ************************************************
    // Line memories
    // ************************************************
    // Row r+2 reuses the line of row r-1 only after its outputs are gone
    always_ff @(posedge i_sys_clk) begin
        if (take) begin
            line_mem[wr_line_r][in_cnt_r[2:0]] <= f_pix;
        end
    end

    // ************************************************
    // Window, padding and multipliers
    // ************************************************
    // One tap per kernel position, row-major like the weights
    for (genvar t = 0; t < conv3x3_pkg::TAPS; t++) begin : g_tap
        localparam int DR = t / 3;                  // 0 above, 2 below
        localparam int DC = t % 3;                  // 0 left, 2 right
        logic [2:0] row, col;
        // Index wraps at the border, but the tap is masked there anyway
        assign row = 3'(out_r[5:3] + 3'(DR) - 3'h1);
        assign col = 3'(out_r[2:0] + 3'(DC) - 3'h1);
        assign tap_ok[t] = (DR == 0 ? out_r[5:3] != 3'h0 :
                            DR == 2 ? out_r[5:3] != conv3x3_pkg::LAST_ROW : 1'b1) &
                           (DC == 0 ? out_r[2:0] != 3'h0 :
                            DC == 2 ? out_r[2:0] != conv3x3_pkg::LAST_COL : 1'b1);
        // Off-image neighbours read as black
        assign tap_pix[t] = tap_ok[t] ? line_mem[line_of(row)][col] : '0;
        // Weights enter straight from the port, no staging
        assign prod[t] = i_kernel[t] * $signed({1'b0, tap_pix[t]});
    end

    // Adder tree over all nine products of the same cycle
    always_comb begin
        full_sum = '0;
        for (int k = 0; k < conv3x3_pkg::TAPS; k++) begin
            full_sum = conv3x3_pkg::ACC_W'(full_sum + conv3x3_pkg::ACC_W'(prod[k]));
        end
    end

    // Pre-add path: three multipliers instead of nine; only exact
    // when corners, edges and centre each share one weight
    assign edge_sum    = 10'(tap_pix[1]) + 10'(tap_pix[3]) + 10'(tap_pix[5]) + 10'(tap_pix[7]);
    assign corner_sum  = 10'(tap_pix[0]) + 10'(tap_pix[2]) + 10'(tap_pix[6]) + 10'(tap_pix[8]);
    assign edge_prod   = i_kernel[1] * $signed({1'b0, edge_sum});
    assign corner_prod = i_kernel[0] * $signed({1'b0, corner_sum});
    assign centre_prod = i_kernel[4] * $signed({1'b0, tap_pix[4]});
    assign sym_sum     = conv3x3_pkg::ACC_W'(edge_prod) + conv3x3_pkg::ACC_W'(corner_prod)
                       + conv3x3_pkg::ACC_W'(centre_prod);

    // ************************************************
    // Checks
    // ************************************************
    // Kernel shape; only the checks below read it
    assign sym_kernel = (i_kernel[0] == i_kernel[2]) && (i_kernel[0] == i_kernel[6]) &&
                        (i_kernel[0] == i_kernel[8]) && (i_kernel[1] == i_kernel[3]) &&
                        (i_kernel[1] == i_kernel[5]) && (i_kernel[1] == i_kernel[7]);

    // Interior windows keep all nine neighbours
    chk_interior_taps: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && out_r[5:3] inside {[3'h1:3'h6]} && out_r[2:0] inside {[3'h1:3'h6]}
        |-> tap_ok == 9'h1FF)
        else $error("interior window lost a neighbour");

    // Row r always lands in line r mod 3, checked on every write
    chk_line_rotate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        take |-> wr_line_r == 2'(in_cnt_r[5:3] % 3'h3))
        else $error("pixel written to the wrong line memory");

    // Weights reach the products without staging
    chk_zero_kernel: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && !i_frame_clr && i_kernel == '0 |=> o_out_valid && o_out_pix.value == '0)
        else $error("zero kernel gave a nonzero pixel");

    // Top row reads nothing above the image
    chk_pad_top: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && out_r[5:3] == 3'h0
        |-> tap_pix[0] == 8'h00 && tap_pix[1] == 8'h00 && tap_pix[2] == 8'h00)
        else $error("top border not padded with zero");

    // Outside sym mode, output is the full sum of its own window
    chk_one_cycle_sum: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && !i_frame_clr && !i_sym_mode |=> o_out_pix.value == $past(full_sum))
        else $error("output is not the sum of the window products");

    // End flag only on the last pixel of a frame
    chk_frame_end: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && !i_frame_clr |=> o_out_pix.frame_end == ($past(out_r) == 6'h3F))
        else $error("frame end not on the 64th output");

    // Pre-add path exact for symmetric kernels
    chk_sym_match: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && sym_kernel |-> sym_sum == full_sum)
        else $error("pre-add path disagrees with direct path");

    // Stalled output must not move
    chk_hold_stall: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        o_out_valid && !i_out_ready && !i_frame_clr |=> o_out_valid && $stable(o_out_pix))
        else $error("output changed while stalled");

    // Clear restarts counters and drops pending work
    chk_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_frame_clr |=> !o_out_valid && in_cnt_r == 6'h00 && out_r == 6'h00 && !calc_r)
        else $error("clear did not restart the frame");

    // Bottom row reads nothing below the image
    chk_pad_bottom: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && out_r[5:3] == conv3x3_pkg::LAST_ROW
        |-> tap_pix[6] == 8'h00 && tap_pix[7] == 8'h00 && tap_pix[8] == 8'h00)
        else $error("bottom border not padded with zero");

    // Left and right columns read nothing beside the image
    chk_pad_sides: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire |-> (out_r[2:0] != 3'h0 || (tap_pix[0] | tap_pix[3] | tap_pix[6]) == 8'h00)
                   && (out_r[2:0] != conv3x3_pkg::LAST_COL
                       || (tap_pix[2] | tap_pix[5] | tap_pix[8]) == 8'h00))
        else $error("side border not padded with zero");

    // Each computed window is the next raster position
    chk_out_order: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        calc_fire && !i_frame_clr |=> o_out_valid && out_r == 6'($past(out_r) + 1'b1))
        else $error("outputs left raster order");

    // Clear also empties the input buffer
    chk_clear_fifo: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_frame_clr |=> o_pix_ready && !f_vld)
        else $error("clear left pixels in the input buffer");

endmodule

// ---- test/conv3x3_stream_model.sv ----
// Pixel source and output consumer standing on both sides of the filter
`timescale 1ns/100ps
module conv3x3_stream_model (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_start,     // Restart source and log
    input  wire logic [6:0]            i_count,     // Pixels to send
    input  wire logic [63:0][7:0]      i_img,       // Image, raster index
    input  wire logic                  i_hold,      // Consumer refuses all
    input  wire logic                  i_jitter,    // Consumer refuses 1 in 4
    output logic                       o_pix_valid,
    output conv3x3_pkg::pix_t          o_pix,
    input  wire logic                  i_pix_ready,
    output logic                       o_out_ready,
    input  wire logic                  i_out_valid,
    input  wire conv3x3_pkg::out_pix_t i_out_pix
);
    // ************************************************
    // State
    // ************************************************
    int                    idx   = 64;              // Next pixel to offer
    int                    lim   = 0;               // Pixels in this run
    int                    n_got = 0;               // Outputs logged
    conv3x3_pkg::out_pix_t got [64];                // Output log, arrival order
    logic                  hold_s = 1'b0;           // Controls sampled on the edge
    logic                  jit_s  = 1'b0;
    logic [1:0]            cyc    = 2'h0;

    // Sample handshakes; controls are sampled here to avoid racing the bench
    always @(posedge i_sys_clk) begin
        hold_s <= i_hold;
        jit_s  <= i_jitter;
        cyc    <= cyc + 2'h1;
        if (i_start) begin
            idx   <= 0;
            lim   <= int'(i_count);
            n_got <= 0;
        end else if (o_pix_valid && i_pix_ready) begin
            idx <= idx + 1;                         // Raster order from top-left
        end
        if (!i_start && i_out_valid && o_out_ready) begin
            if (n_got < 64) begin
                got[n_got] <= i_out_pix;
            end
            n_got <= n_got + 1;
        end
    end

    // Drive after the edge; idle data toggles so stale values never match
    always @(negedge i_sys_clk) begin
        o_pix_valid <= (idx < lim);
        o_pix       <= (idx < lim) ? i_img[idx[5:0]] : {4{cyc}}; // 8-bit, 0..255
        o_out_ready <= !hold_s && !(jit_s && (cyc == 2'h0));
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the 3x3 convolution filter
`timescale 1ns/100ps
module testbench;
    // ************************************************
    // Signals
    // ************************************************
    logic                  i_sys_clk = 1'b0;
    logic                  i_rstn, i_frame_clr, i_sym_mode, start, hold, jitter;
    logic                  pix_valid, pix_ready, out_valid, out_ready;
    logic [6:0]            count;
    logic [63:0][7:0]      img;
    conv3x3_pkg::pix_t     pix;
    conv3x3_pkg::kernel_t  kernel;
    conv3x3_pkg::out_pix_t out_pix, seen;
    int                    n_fail = 0;
    int                    n_tests = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    conv3x3_filter dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_frame_clr(i_frame_clr),
        .i_pix_valid(pix_valid), .i_pix(pix), .o_pix_ready(pix_ready), .i_kernel(kernel),
        .i_sym_mode(i_sym_mode), .o_out_valid(out_valid), .o_out_pix(out_pix),
        .i_out_ready(out_ready));
    conv3x3_stream_model model (.i_sys_clk(i_sys_clk), .i_start(start), .i_count(count),
        .i_img(img), .i_hold(hold), .i_jitter(jitter), .o_pix_valid(pix_valid), .o_pix(pix),
        .i_pix_ready(pix_ready), .o_out_ready(out_ready), .i_out_valid(out_valid),
        .i_out_pix(out_pix));

    // ************************************************
    // Helpers
    // ************************************************
    // Reference value, zero outside the image; sym uses corner/edge/centre
    function automatic logic signed [20:0] expect_pix(input int r, input int c);
        int s, t, rr, cc, w;
        s = 0;
        for (t = 0; t < 9; t++) begin
            rr = r - 1 + t / 3;
            cc = c - 1 + t % 3;
            if (i_sym_mode) begin
                w = (t == 4) ? int'(kernel[4]) : (t % 2 == 0) ? int'(kernel[0]) : int'(kernel[1]);
            end else begin
                w = int'(kernel[t]);
            end
            if (rr >= 0 && rr < 8 && cc >= 0 && cc < 8) begin
                s += w * int'(img[rr * 8 + cc]);
            end
        end
        return s[20:0];
    endfunction

    task automatic check_val(input logic signed [20:0] got, input logic signed [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: pixel value %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask

    task automatic start_frame(input logic [6:0] n);
        count = n;
        @(negedge i_sys_clk) start = 1'b1;
        @(negedge i_sys_clk) start = 1'b0;
    endtask

    // Wait for all outputs, then compare every pixel in raster order
    task automatic finish_frame();
        int i;
        i = 0;
        while (model.n_got < 64 && i < 3000) begin
            @(negedge i_sys_clk);
            i++;
        end
        repeat (6) @(negedge i_sys_clk);
        check_bit(model.n_got == 64, 1'b1, "one output per input");
        for (i = 0; i < 64; i++) begin
            check_val(model.got[i].value, expect_pix(i / 8, i % 8));
            check_bit(model.got[i].frame_end, i == 63, "frame end flag");
        end
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    // Mixed signed weights, two frames back to back through the line rotation
    task automatic test_full();
        for (int i = 0; i < 64; i++) img[i] = 8'((i * 37) + 11);
        kernel = {9'h0FF, 9'h100, 9'h003, 9'h1F9, 9'h07F, 9'h181, 9'h010, 9'h1FF, 9'h055};
        start_frame(7'h40);
        finish_frame();
        for (int i = 0; i < 64; i++) img[i] = 8'((i * 91) ^ 8'hA5);
        start_frame(7'h40);
        finish_frame();
    endtask

    // Extreme weights on a white image: largest negative and positive sums
    task automatic test_extremes();
        img = {64{8'hFF}};
        kernel = {9{9'h100}};
        start_frame(7'h40);
        finish_frame();
        kernel = {9{9'h0FF}};
        start_frame(7'h40);
        finish_frame();
    endtask

    // Pre-add path; unused weights hold junk that must be ignored
    task automatic test_sym();
        for (int i = 0; i < 64; i++) img[i] = 8'(255 - i * 3);
        kernel = {{4{9'h155}}, 9'h11C, 9'h0AA, 9'h1E7, 9'h03D, 9'h1C3};
        i_sym_mode = 1'b1;
        start_frame(7'h40);
        finish_frame();
        i_sym_mode = 1'b0;
    endtask

    // Consumer stalls: FIFO fills and refuses, held output stands, then drains
    task automatic test_stall();
        int i;
        hold = 1'b1;
        start_frame(7'h40);
        i = 0;
        while (pix_ready !== 1'b0 && i < 200) begin
            @(negedge i_sys_clk);
            i++;
        end
        check_bit(pix_ready, 1'b0, "input refused when full");
        check_bit(out_valid, 1'b1, "output waiting");
        seen = out_pix;
        repeat (5) @(negedge i_sys_clk);
        check_bit(out_pix === seen, 1'b1, "held output stable");
        hold = 1'b0;
        finish_frame();
        jitter = 1'b1;
        start_frame(7'h40);
        finish_frame();
        jitter = 1'b0;
    endtask

    // Clear in mid-frame: the next pixel counts as the top-left one;
    // the cut frame runs on zero weights, so its last output, still held, must be zero
    task automatic test_clear();
        kernel = '0;
        start_frame(7'h14);
        repeat (40) @(negedge i_sys_clk);
        check_bit(model.n_got == 11, 1'b1, "outputs of a cut frame");
        check_val(out_pix.value, '0);
        i_frame_clr = 1'b1;
        @(negedge i_sys_clk) i_frame_clr = 1'b0;
        check_bit(out_valid, 1'b0, "valid after clear");
        check_bit(pix_ready, 1'b1, "ready after clear");
        kernel = {3{9'h011, 9'h1EE, 9'h07B}};
        start_frame(7'h40);
        finish_frame();
    endtask

    // ************************************************
    // Run control
    // ************************************************
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Nine frames of about 100 cycles each fit well inside this span
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        i_rstn = 1'b0;
        i_frame_clr = 1'b0;
        i_sym_mode = 1'b0;
        start = 1'b0;
        hold = 1'b0;
        jitter = 1'b0;
        count = 7'h00;
        img = '0;
        kernel = '0;
        repeat (16) @(negedge i_sys_clk);
        check_bit(out_valid, 1'b0, "valid in reset");
        i_rstn = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        check_bit(pix_ready, 1'b1, "ready after reset");
        test_full();
        test_extremes();
        test_sym();
        test_stall();
        test_clear();
        test_done();
    end
endmodule
